// ### rtl/mapper_pkg.sv
`default_nettype none
package mapper_pkg;

    typedef enum logic [3:0]
    {
        MODE_AM24 = 4'h1,
        MODE_AM18 = 4'h2,
        MODE_DS16 = 4'h4,
        MODE_DS24 = 4'h8
    } mode_type;

    localparam mode_type MODE_RESET = MODE_AM24;
    localparam logic [1:0] XFER_FIRST = 2'h0;
    localparam logic [1:0] DS16_LAST = 2'h2;
    localparam logic [1:0] DS24_LAST = 2'h1;
    localparam logic [1:0] AM_LAST = 2'h0;
    localparam logic [23:0] DATA_RESET = 24'h000000;
    localparam logic [1:0] CTL_RESET = 2'h0;
    localparam int DS16_SHIFT_BIT = 16;

    typedef struct packed
    {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } pixel_type;

    // one bit per colour for eight columns in each panel half
    typedef struct packed
    {
        logic [7:0] ur;
        logic [7:0] ug;
        logic [7:0] ub;
        logic [7:0] lr;
        logic [7:0] lg;
        logic [7:0] lb;
    } group_type;

    typedef struct packed
    {
        logic hsync;
        logic vsync;
        logic link_lock_sync;
        logic ctrl_bit_1;
        logic ctrl_bit_2;
        logic ctrl_bit_3;
    } ctrl_type;

    // ctlN[0] and ctlN[1] are the two control inputs of data channel N
    typedef struct packed
    {
        logic data_enable;
        logic [1:0] ctl0;
        logic [1:0] ctl1;
        logic [1:0] ctl2;
        logic [23:0] data;
    } link_word_type;

endpackage
`default_nettype wire

// ### rtl/panel_pixel_channel_mapper.sv
`timescale 1ns/100ps
`default_nettype none
module panel_pixel_channel_mapper
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] mode_sel,
    output logic link_active_q,
    input wire logic pixel_clock,
    input wire logic data_enable,
    input wire mapper_pkg::ctrl_type ctrl_in,
    input wire mapper_pkg::pixel_type pixel_in,
    input wire mapper_pkg::group_type group_in,
    output mapper_pkg::link_word_type link_word_q,
    output logic fetch_q
);

    // ---------------- configuration side (clk) ----------------
    logic [3:0] mode_q;
    logic act1_q;
    logic act2_q;
    logic act3_q;

    // a one-hot code with more than one bit set is ignored; the last legal mode stays
    wire mode_legal = (mode_sel == mapper_pkg::MODE_AM24) || (mode_sel == mapper_pkg::MODE_AM18)
                   || (mode_sel == mapper_pkg::MODE_DS16) || (mode_sel == mapper_pkg::MODE_DS24);
    wire [3:0] mode_d = mode_legal ? mode_sel : mode_q;
    wire active_d = (act2_q == act3_q) ? act3_q : link_active_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_q <= mapper_pkg::MODE_RESET;
            act1_q <= 1'b0;
            act2_q <= 1'b0;
            act3_q <= 1'b0;
            link_active_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            act1_q <= link_word_q.data_enable;
            act2_q <= act1_q;
            act3_q <= act2_q;
            link_active_q <= active_d;
        end
    end

    // ---------------- link side (pixel_clock) ----------------
    logic [1:0] lrst_q;
    wire lrst_b = lrst_q[1];

    // asynchronous assert, release aligned to the pixel clock
    always_ff @(posedge pixel_clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lrst_q <= 2'b00;
        end
        else
        begin
            lrst_q <= {lrst_q[0], 1'b1};
        end
    end

    logic [3:0] msync1_q;
    logic [3:0] msync2_q;
    logic [3:0] msync3_q;
    logic [3:0] mode_sync_q;
    mapper_pkg::mode_type mode_l_q;
    logic [1:0] xfer_q;
    logic shf_q;
    mapper_pkg::group_type grp_q;
    mapper_pkg::ctrl_type ctrl_l_q;

    // the whole word must agree so a half-changed code is never taken
    wire [3:0] mode_sync_d = (msync2_q == msync3_q) ? msync3_q : mode_sync_q;

    always_ff @(posedge pixel_clock or negedge lrst_b)
    begin
        if (!lrst_b)
        begin
            msync1_q <= mapper_pkg::MODE_RESET;
            msync2_q <= mapper_pkg::MODE_RESET;
            msync3_q <= mapper_pkg::MODE_RESET;
            mode_sync_q <= mapper_pkg::MODE_RESET;
        end
        else
        begin
            msync1_q <= mode_q;
            msync2_q <= msync1_q;
            msync3_q <= msync2_q;
            mode_sync_q <= mode_sync_d;
        end
    end

    // index of the last transfer in the sequence of the mode in force
    logic [1:0] xfer_last;
    always_comb
    begin
        case (mode_l_q)
            mapper_pkg::MODE_DS16: xfer_last = mapper_pkg::DS16_LAST;
            mapper_pkg::MODE_DS24: xfer_last = mapper_pkg::DS24_LAST;
            default: xfer_last = mapper_pkg::AM_LAST;
        endcase
    end

    wire xfer_first = (xfer_q == mapper_pkg::XFER_FIRST);
    wire [1:0] xfer_next = (xfer_q == xfer_last) ? mapper_pkg::XFER_FIRST : xfer_q + 2'h1;
    // first transfer takes the group straight from the source, later ones from the copy
    wire mapper_pkg::group_type grp_cur = xfer_first ? group_in : grp_q;

    // colour-interleaved bit streams R0,G0,B0,... of each half
    logic [23:0] useq;
    logic [23:0] lseq;
    logic [23:0] ds24_word;
    wire [4:0] ds16_shift = {xfer_q, 3'b000};
    wire [2:0] ds24_shift = {xfer_q[0], 2'b00};
    wire [7:0] ur_t = grp_cur.ur >> ds24_shift;
    wire [7:0] ug_t = grp_cur.ug >> ds24_shift;
    wire [7:0] ub_t = grp_cur.ub >> ds24_shift;
    wire [7:0] lr_t = grp_cur.lr >> ds24_shift;
    wire [7:0] lg_t = grp_cur.lg >> ds24_shift;
    wire [7:0] lb_t = grp_cur.lb >> ds24_shift;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_seq
            assign useq[3*gi +: 3] = {grp_cur.ub[gi], grp_cur.ug[gi], grp_cur.ur[gi]};
            assign lseq[3*gi +: 3] = {grp_cur.lb[gi], grp_cur.lg[gi], grp_cur.lr[gi]};
        end
        for (gi = 0; gi < 4; gi++)
        begin : g_ds24
            // upper triple then lower triple of the same column
            assign ds24_word[6*gi +: 6] = {lb_t[gi], lg_t[gi], lr_t[gi],
                                           ub_t[gi], ug_t[gi], ur_t[gi]};
        end
    endgenerate

    wire [23:0] useq_t = useq >> ds16_shift;
    wire [23:0] lseq_t = lseq >> ds16_shift;
    wire [23:0] am24_word = {pixel_in.red, pixel_in.green, pixel_in.blue};
    wire [23:0] am18_word = {pixel_in.red[5:0], 2'b00, pixel_in.green[5:0], 2'b00,
                             pixel_in.blue[5:0], 2'b00};
    wire [23:0] ds16_word = {7'h00, ~shf_q, lseq_t[7:4], useq_t[7:4],
                             lseq_t[3:0], useq_t[3:0]};

    logic [23:0] mapped;
    always_comb
    begin
        case (mode_l_q)
            mapper_pkg::MODE_AM24: mapped = am24_word;
            mapper_pkg::MODE_AM18: mapped = am18_word;
            mapper_pkg::MODE_DS16: mapped = ds16_word;
            mapper_pkg::MODE_DS24: mapped = ds24_word;
            default: mapped = mapper_pkg::DATA_RESET;
        endcase
    end

    // controls are frozen over the active period, as the encoder only codes them in blanking
    wire mapper_pkg::ctrl_type ctrl_d = data_enable ? ctrl_l_q : ctrl_in;
    wire [23:0] data_d = data_enable ? mapped : mapper_pkg::DATA_RESET;
    wire fetch_d = data_enable && ((mode_l_q == mapper_pkg::MODE_AM24)
                                || (mode_l_q == mapper_pkg::MODE_AM18) || xfer_first);

    // mode changes only take effect in blanking so a sequence is never split
    always_ff @(posedge pixel_clock or negedge lrst_b)
    begin
        if (!lrst_b)
        begin
            mode_l_q <= mapper_pkg::MODE_RESET;
            xfer_q <= mapper_pkg::XFER_FIRST;
            shf_q <= 1'b0;
            grp_q <= '0;
        end
        else if (!data_enable)
        begin
            mode_l_q <= mapper_pkg::mode_type'(mode_sync_q);
            xfer_q <= mapper_pkg::XFER_FIRST;
            shf_q <= 1'b0;
        end
        else
        begin
            xfer_q <= xfer_next;
            shf_q <= ~shf_q;
            if (xfer_first)
            begin
                grp_q <= group_in;
            end
        end
    end

    always_ff @(posedge pixel_clock or negedge lrst_b)
    begin
        if (!lrst_b)
        begin
            ctrl_l_q <= '0;
            link_word_q <= '0;
            fetch_q <= 1'b0;
        end
        else
        begin
            ctrl_l_q <= ctrl_d;
            link_word_q.data_enable <= data_enable;
            link_word_q.ctl0 <= {ctrl_d.vsync, ctrl_d.hsync};
            link_word_q.ctl1 <= {ctrl_d.ctrl_bit_1, ctrl_d.link_lock_sync};
            link_word_q.ctl2 <= {ctrl_d.ctrl_bit_3, ctrl_d.ctrl_bit_2};
            link_word_q.data <= data_d;
            fetch_q <= fetch_d;
        end
    end

    // ---------------- checks ----------------
    chk_blank_data_zero: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        !data_enable |=> (link_word_q.data == 24'h000000) && !link_word_q.data_enable)
        else $error("data bus not zero in blanking");

    chk_ch0_sync_pair: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        !data_enable |=> link_word_q.ctl0 == {$past(ctrl_in.vsync), $past(ctrl_in.hsync)})
        else $error("channel 0 control pair wrong");

    chk_ch1_ctrl_pair: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        !data_enable |=> link_word_q.ctl1
            == {$past(ctrl_in.ctrl_bit_1), $past(ctrl_in.link_lock_sync)})
        else $error("channel 1 control pair wrong");

    chk_ch2_ctrl_pair: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        !data_enable |=> link_word_q.ctl2
            == {$past(ctrl_in.ctrl_bit_3), $past(ctrl_in.ctrl_bit_2)})
        else $error("channel 2 control pair wrong");

    chk_ctrl_frozen_active: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && $past(data_enable)
            |=> $stable(link_word_q.ctl0) && $stable(link_word_q.ctl1)
                && $stable(link_word_q.ctl2))
        else $error("control levels moved in active period");

    chk_am24_lanes: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && mode_l_q == mapper_pkg::MODE_AM24
            |=> link_word_q.data == $past(am24_word) && link_word_q.data_enable)
        else $error("24 bpp lane placement wrong");

    chk_am18_low_zero: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && mode_l_q == mapper_pkg::MODE_AM18
            |=> link_word_q.data[1:0] == 2'h0 && link_word_q.data[17:16] == 2'h0
                && link_word_q.data[7:2] == $past(pixel_in.blue[5:0]))
        else $error("18 bpp placement wrong");

    chk_ds16_first_bits: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && xfer_first && mode_l_q == mapper_pkg::MODE_DS16
            |=> link_word_q.data[0] == $past(group_in.ur[0])
                && link_word_q.data[4] == $past(group_in.lr[0])
                && link_word_q.data[11] == $past(group_in.ug[2]))
        else $error("16 bpp first transfer wrong");

    chk_ds16_shift_nc: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && mode_l_q == mapper_pkg::MODE_DS16 ##1 data_enable
            |=> link_word_q.data[23:17] == 7'h00
                && link_word_q.data[16] != $past(link_word_q.data[16]))
        else $error("shift clock lane wrong");

    chk_ds24_column: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && xfer_first && mode_l_q == mapper_pkg::MODE_DS24
            |=> link_word_q.data[3] == $past(group_in.lr[0])
                && link_word_q.data[10] == $past(group_in.lg[1]))
        else $error("24 bpp dual scan placement wrong");

    chk_seq_back_to_back: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && !$past(data_enable) && mode_l_q == mapper_pkg::MODE_DS16
            |-> xfer_first ##1 (!data_enable || xfer_q == 2'h1))
        else $error("sequence did not start at first transfer");

    chk_active_flag: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable |=> link_word_q.data_enable)
        else $error("data enable not carried to the link word");

    chk_am18_upper: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && mode_l_q == mapper_pkg::MODE_AM18
            |=> link_word_q.data[9:8] == 2'h0
                && link_word_q.data[15:10] == $past(pixel_in.green[5:0])
                && link_word_q.data[23:18] == $past(pixel_in.red[5:0]))
        else $error("18 bpp green or red placement wrong");

    // later transfers come from the stored copy, so these look at grp_q, not group_in
    chk_ds16_second: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && xfer_q == 2'h1 && mode_l_q == mapper_pkg::MODE_DS16
            |=> link_word_q.data[0] == $past(grp_q.ub[2])
                && link_word_q.data[12] == $past(grp_q.lr[4]))
        else $error("16 bpp second transfer wrong");

    chk_ds16_third: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && xfer_q == mapper_pkg::DS16_LAST && mode_l_q == mapper_pkg::MODE_DS16
            |=> link_word_q.data[0] == $past(grp_q.ug[5])
                && link_word_q.data[15] == $past(grp_q.lb[7]))
        else $error("16 bpp third transfer wrong");

    chk_ds16_nc_zero: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && mode_l_q == mapper_pkg::MODE_DS16
            |=> link_word_q.data[23:17] == 7'h00)
        else $error("unconnected lanes not zero");

    chk_ds16_shift_start: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && !$past(data_enable) && mode_l_q == mapper_pkg::MODE_DS16
            |=> link_word_q.data[16] == 1'b1)
        else $error("shift clock not high on first transfer");

    chk_ds24_second: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && xfer_q == mapper_pkg::DS24_LAST && mode_l_q == mapper_pkg::MODE_DS24
            |=> link_word_q.data[0] == $past(grp_q.ur[4])
                && link_word_q.data[9] == $past(grp_q.lr[5])
                && link_word_q.data[23] == $past(grp_q.lb[7]))
        else $error("24 bpp dual scan second transfer wrong");

    chk_ds24_seq_start: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && !$past(data_enable) && mode_l_q == mapper_pkg::MODE_DS24
            |-> xfer_first)
        else $error("24 bpp dual scan sequence did not start at first transfer");

    chk_fetch_first: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && xfer_first |=> fetch_q)
        else $error("no fetch after a first transfer");

    chk_fetch_mid: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && !xfer_first |=> !fetch_q)
        else $error("fetch inside a running sequence");

    chk_fetch_idle: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        !data_enable |=> !fetch_q)
        else $error("fetch during blanking");

    chk_mode_held_active: assert property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable |=> $stable(mode_l_q))
        else $error("mode changed inside an active period");

    cov_am24_active: cover property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && mode_l_q == mapper_pkg::MODE_AM24);
    cov_ds16_full: cover property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && mode_l_q == mapper_pkg::MODE_DS16 && xfer_q == mapper_pkg::DS16_LAST);
    cov_ds24_second: cover property (@(posedge pixel_clock) disable iff (!lrst_b)
        data_enable && mode_l_q == mapper_pkg::MODE_DS24 && xfer_q == mapper_pkg::DS24_LAST);
    cov_mode_change: cover property (@(posedge pixel_clock) disable iff (!lrst_b)
        !data_enable && mode_l_q != mode_sync_q);
    cov_link_active: cover property (@(posedge clk) disable iff (!rst_b)
        $rose(link_active_q));

endmodule
`default_nettype wire

// ### verification/link_encoder_model.sv
`timescale 1ns/100ps
`default_nettype none
module link_encoder_model
(
    input wire mapper_pkg::link_word_type word,
    output logic [8:0] sym0,
    output logic [8:0] sym1,
    output logic [8:0] sym2
);
    // symbol = {is_control, payload}; the 10-bit coding itself is not modelled
    assign sym0 = word.data_enable ? {1'b0, word.data[7:0]} : {7'h40, word.ctl0};
    assign sym1 = word.data_enable ? {1'b0, word.data[15:8]} : {7'h40, word.ctl1};
    assign sym2 = word.data_enable ? {1'b0, word.data[23:16]} : {7'h40, word.ctl2};
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e, m) \
    begin \
        n_tests++; \
        if ((a) !== (e)) \
        begin \
            n_mismatch++; \
            $display("MISMATCH %0t %s", $time, m); \
        end \
    end
module testbench;
    localparam logic [47:0] G1 = 48'h9c3ae561b2d7;
    localparam logic [47:0] G2 = 48'h5be1047fa39c;
    logic clk = 1'b0;
    logic pixel_clock = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] mode_sel = 4'h1;
    logic data_enable = 1'b0;
    mapper_pkg::ctrl_type ctrl_in = '0;
    mapper_pkg::pixel_type pixel_in = '0;
    mapper_pkg::group_type group_in = '0;
    wire logic link_active_q;
    wire mapper_pkg::link_word_type link_word_q;
    wire logic fetch_q;
    wire logic [8:0] sym0;
    wire logic [8:0] sym1;
    wire logic [8:0] sym2;
    int n_mismatch = 0;
    int n_tests = 0;

    initial forever #10 clk = ~clk;
    // link clock offset so its edges never line up with clk
    initial
    begin
        #7;
        forever #80 pixel_clock = ~pixel_clock;
    end

    panel_pixel_channel_mapper uut
    (
        .clk(clk),
        .rst_b(rst_b),
        .mode_sel(mode_sel),
        .link_active_q(link_active_q),
        .pixel_clock(pixel_clock),
        .data_enable(data_enable),
        .ctrl_in(ctrl_in),
        .pixel_in(pixel_in),
        .group_in(group_in),
        .link_word_q(link_word_q),
        .fetch_q(fetch_q)
    );

    link_encoder_model partner
    (
        .word(link_word_q),
        .sym0(sym0),
        .sym1(sym1),
        .sym2(sym2)
    );

    task give_verdict;
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // output seen at the negedge belongs to the inputs of the previous step
    task step(input logic d, input mapper_pkg::ctrl_type c, input mapper_pkg::pixel_type p,
              input mapper_pkg::group_type g);
        @(posedge pixel_clock);
        data_enable <= d;
        ctrl_in <= c;
        pixel_in <= p;
        group_in <= g;
        @(negedge pixel_clock);
    endtask

    task chk_blank(input mapper_pkg::ctrl_type c);
        `CHK(link_word_q.data_enable, 1'b0, "enable in blanking")
        `CHK(link_word_q.ctl0, {c.vsync, c.hsync}, "channel 0 controls")
        `CHK(link_word_q.ctl1, {c.ctrl_bit_1, c.link_lock_sync}, "channel 1 controls")
        `CHK(link_word_q.ctl2, {c.ctrl_bit_3, c.ctrl_bit_2}, "channel 2 controls")
        `CHK(link_word_q.data, 24'h000000, "data in blanking")
        `CHK(sym0, {7'h40, c.vsync, c.hsync}, "channel 0 symbol")
        `CHK(sym1, {7'h40, c.ctrl_bit_1, c.link_lock_sync}, "channel 1 symbol")
        `CHK(sym2, {7'h40, c.ctrl_bit_3, c.ctrl_bit_2}, "channel 2 symbol")
    endtask

    task set_mode(input logic [3:0] m);
        @(posedge clk);
        mode_sel <= m;
        repeat (8) step(1'b0, '0, '0, '0);
    endtask

    function automatic logic [23:0] ds16(input mapper_pkg::group_type g, input int t,
                                         input logic sh);
        logic [23:0] u;
        logic [23:0] l;
        logic [23:0] r;
        for (int p = 0; p < 8; p++)
        begin
            u[3*p +: 3] = {g.ub[p], g.ug[p], g.ur[p]};
            l[3*p +: 3] = {g.lb[p], g.lg[p], g.lr[p]};
        end
        r = '0;
        r[3:0] = u[8*t +: 4];
        r[11:8] = u[8*t+4 +: 4];
        r[7:4] = l[8*t +: 4];
        r[15:12] = l[8*t+4 +: 4];
        r[16] = sh;
        return r;
    endfunction

    function automatic logic [23:0] ds24(input mapper_pkg::group_type g, input int t);
        logic [23:0] r;
        int q;
        for (int i = 0; i < 4; i++)
        begin
            q = 4*t + i;
            r[6*i +: 6] = {g.lb[q], g.lg[q], g.lr[q], g.ub[q], g.ug[q], g.ur[q]};
        end
        return r;
    endfunction

    task t_am24;
        mapper_pkg::ctrl_type c;
        int n;
        for (int i = 0; i < 4; i++)
        begin
            c = mapper_pkg::ctrl_type'({3{2'(i)}});
            step(1'b0, c, '0, '0);
            step(1'b0, c, '0, '0);
            chk_blank(c);
        end
        step(1'b1, '0, 24'ha5c33c, '0);
        step(1'b1, '0, 24'h5a0ff0, '0);
        `CHK(link_word_q.data, 24'ha5c33c, "am24 pixel")
        `CHK(link_word_q.ctl0, 2'h3, "controls frozen while active")
        `CHK(fetch_q, 1'b1, "fetch while active")
        `CHK(sym0, 9'h03c, "channel 0 data symbol")
        n = 0;
        while (link_active_q !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 40)
        begin
            n_mismatch++;
            give_verdict();
        end
        `CHK(link_active_q, 1'b1, "link active while data flows")
        step(1'b0, '0, '0, '0);
        `CHK(link_word_q.data, 24'h5a0ff0, "am24 second pixel")
        step(1'b0, '0, '0, '0);
        chk_blank('0);
    endtask

    task t_am18;
        mapper_pkg::pixel_type p;
        logic [23:0] want;
        p = 24'hc7e9ab;
        want = {p.red[5:0], 2'h0, p.green[5:0], 2'h0, p.blue[5:0], 2'h0};
        set_mode(4'h2);
        `CHK(link_active_q, 1'b0, "link idle in blanking")
        // an illegal code must leave the mode alone
        set_mode(4'h6);
        step(1'b1, '0, p, '0);
        step(1'b0, '0, '0, '0);
        `CHK(link_word_q.data, want, "am18")
    endtask

    task t_ds16;
        logic [23:0] want;
        set_mode(4'h4);
        for (int k = 0; k < 5; k++)
        begin
            step(k < 4, '0, '0, k == 0 ? G1 : (k == 3 ? G2 : ~G1));
            if (k > 0)
            begin
                want = ds16(k == 4 ? G2 : G1, (k-1) % 3, (k-1) % 2 == 0);
                `CHK(link_word_q.data, want, "ds16")
                `CHK(fetch_q, k == 1 || k == 4, "ds16 fetch")
            end
        end
        step(1'b0, '0, '0, '0);
        chk_blank('0);
    endtask

    task t_ds24;
        logic [23:0] want;
        set_mode(4'h8);
        for (int k = 0; k < 4; k++)
        begin
            step(k < 3, '0, '0, k == 0 ? G1 : (k == 2 ? G2 : ~G1));
            if (k > 0)
            begin
                want = ds24(k == 3 ? G2 : G1, (k-1) % 2);
                `CHK(link_word_q.data, want, "ds24")
                `CHK(fetch_q, k != 2, "ds24 fetch")
            end
        end
        step(1'b0, '0, '0, '0);
        chk_blank('0);
    endtask

    initial
    begin
        repeat (4) @(posedge pixel_clock);
        `CHK(link_word_q, 31'h0, "word during reset")
        rst_b <= 1'b1;
        repeat (3) step(1'b0, '0, '0, '0);
        t_am24();
        t_am18();
        t_ds16();
        t_ds24();
        give_verdict();
    end
endmodule
`default_nettype wire
